/* File: design/acm_pkg.sv */
package acm_pkg;

    // Register byte offsets
    localparam logic [7:0] ACM_CFG_FIRST_OFS = 8'h00;
    localparam logic [7:0] ACM_VSRC_OFS      = 8'h04;
    localparam logic [7:0] ACM_CFG_FOUR_OFS  = 8'h08;
    localparam logic [7:0] ACM_PORT_CFG_OFS  = 8'h0C;
    localparam logic [7:0] ACM_CTRL_OFS      = 8'h10;
    localparam logic [7:0] ACM_STATUS_OFS    = 8'h14;

    // Field positions
    localparam int ACM_RATE_LSB    = 0;
    localparam int ACM_FILT_LSB    = 4;
    localparam int ACM_NEG_LSB     = 0;
    localparam int ACM_POS_LSB     = 2;
    localparam int ACM_CON_LSB     = 0;
    localparam int ACM_DIR_LSB     = 4;
    localparam int ACM_EXC_BIT     = 0;
    localparam int ACM_AH_BIT      = 0;
    localparam int ACM_AL_BIT      = 1;
    localparam int ACM_VL_BIT      = 2;
    localparam int ACM_SETTLED_BIT = 3;

    // Reset values
    localparam logic [3:0] ACM_RATE_RST = 4'h4;
    localparam logic [2:0] ACM_FILT_RST = 3'h0;
    localparam logic [3:0] ACM_VSRC_RST = 4'h5;
    localparam logic [3:0] ACM_CON_RST  = 4'h0;
    localparam logic [3:0] ACM_DIR_RST  = 4'hF;
    localparam logic [3:0] ACM_DATA_RST = 4'h0;

    // Voltage source selector codes; 2'h3 also picks the analog input
    localparam logic [1:0] ACM_SRC_AIN    = 2'h0;
    localparam logic [1:0] ACM_SRC_SUPPLY = 2'h1;
    localparam logic [1:0] ACM_SRC_EXT0   = 2'h2;

    // Filter field: 0..3 sinc order 1..4, 4 selects FIR
    localparam logic [2:0] ACM_FILT_FIR = 3'h4;

    // Clock ratios: modulator = clock / 8, first stage to 14400 SPS
    localparam int ACM_MOD_DIV = 8;
    localparam int ACM_INT_DIV = 64;
    localparam int ACM_RW      = 13;

    // Second stage ratio per rate code, from 14400 SPS
    // 2.5 5 10 16.6 20 50 60 100 400 1200 2400 4800 7200
    localparam logic [12:0] ACM_RATIO [13] = '{
        13'h1680, 13'h0B40, 13'h05A0, 13'h0360, 13'h02D0,
        13'h0120, 13'h00F0, 13'h0090, 13'h0024, 13'h000C,
        13'h0006, 13'h0003, 13'h0002};
    localparam logic [3:0] ACM_RATE_MAX = 4'hC;
    localparam logic [3:0] ACM_FIR_MAX  = 4'h4;

    typedef enum logic [1:0] {
        ACM_SETTLE = 2'b01,
        ACM_READY  = 2'b10
    } acm_filt_st_t;

endpackage

/* File: design/acm_sync.sv */
`timescale 1ns/1ps
module acm_sync #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            dout_q <= '0;
        end else begin
            meta_q <= din;
            dout_q <= meta_q;
        end
    end
endmodule

/* File: design/acm_rate_div.sv */
`timescale 1ns/1ps
module acm_rate_div #(
    parameter int W = 13
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         en,
    input  wire logic         restart,
    input  wire logic [W-1:0] ratio,
    output logic              tick_q
);
    logic [W-1:0] cnt_q;
    logic         wrap;

    assign wrap = cnt_q >= ratio - W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (restart) begin
            cnt_q <= '0;
        end else if (en) begin
            cnt_q <= wrap ? '0 : cnt_q + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= en && !restart && wrap;
        end
    end
endmodule

/* File: design/acm_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - High alarm sets when either amplifier output nears the upper supply.
// - Low alarm sets when either amplifier output nears the lower supply.
// - Alarms are read-only; cleared at conversion start once condition ends.
// - Over-range comparators are ignored while the input mux switches.
// - Two 2-bit source selectors; reset selects the analog supply pair.
// - Positive: supply, external in 0, analog in 0; negative likewise.
// - Writing 0Ah selects the external positive and negative inputs 0.
// - Writing 05h selects the analog supply pair.
// - Low source alarm sets below 0.4 V, clears at next conversion.
// - Four port pins share analog inputs 0 to 3.
// - A port pin reaches its package pin only when its connect bit is 1.
// - Direction bit 0 drives the pin, 1 makes it an input unless excitation mode is on.
// - Port pin values are read and written in the fourth config word.
// - Output pins read back the written value, not the pin level.
// - Excitation mode drives pins with excitation signals, ignoring data.
// - Modulator samples at the converter clock divided by 8.
// - Sinc mode gives 2.5 to 7200 SPS with order 1 through 4.
// - FIR mode gives up to 20 SPS, settled in one conversion.
// - First stage decimates the modulator stream to 14400 SPS.
// - Second stage applies programmable ratio and order.
// - Output rate comes from a 4-bit field of the first config word.
// - Filter mode and order come from a 3-bit field of that word.
module acm_ctrl
    import acm_pkg::*;
#(
    parameter int MOD_DIV = ACM_MOD_DIV,
    parameter int INT_DIV = ACM_INT_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        amp_hi_cmp,
    input  wire logic        amp_lo_cmp,
    input  wire logic        vsrc_low_cmp,
    input  wire logic        mux_switching,
    input  wire logic [3:0]  exc_drive,
    input  wire logic [3:0]  port_pin_in,
    output logic      [3:0]  port_pin_out,
    output logic      [3:0]  port_pin_oe_n,
    output logic      [1:0]  pos_vsrc_sel,
    output logic      [1:0]  neg_vsrc_sel,
    output logic             amp_high_alarm,
    output logic             amp_low_alarm,
    output logic             low_vsrc_alarm,
    output logic             mod_en,
    output logic             int_en,
    output logic             conv_start,
    output logic             data_ready,
    output logic             fir_mode,
    output logic      [1:0]  sinc_order,
    output logic      [12:0] decim_ratio
);

    logic [7:0]   sync_s;
    logic [3:0]   pin_s;
    logic         hi_s;
    logic         lo_s;
    logic         vl_s;
    logic         mux_s;
    logic         wr;
    logic         wr_first;
    logic         restart;
    logic [3:0]   rate_q;
    logic [2:0]   filt_q;
    logic [3:0]   con_q;
    logic [3:0]   dir_q;
    logic [3:0]   data_q;
    logic         exc_q;
    logic [3:0]   rate_eff;
    logic [12:0]  ratio_d;
    logic [2:0]   need;
    logic [2:0]   settle_q;
    logic [31:0]  rdata_d;
    logic         hit;
    acm_filt_st_t st_q;

    // Set wins over clear so an event in the clear cycle is kept
    function automatic logic alarm_next(logic q, logic cond, logic clr);
        return cond ? 1'b1 : (clr ? 1'b0 : q);
    endfunction

    acm_sync #(
        .W (8)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({mux_switching, vsrc_low_cmp, amp_lo_cmp, amp_hi_cmp,
                   port_pin_in}),
        .dout_q  (sync_s)
    );

    assign pin_s = sync_s[3:0];
    assign hi_s  = sync_s[4];
    assign lo_s  = sync_s[5];
    assign vl_s  = sync_s[6];
    assign mux_s = sync_s[7];

    // APB: pready comes one cycle after setup, so each access has no wait
    assign wr       = psel && penable && pready && pwrite;
    assign wr_first = wr && paddr == ACM_CFG_FIRST_OFS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_comb begin
        hit     = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            ACM_CFG_FIRST_OFS: begin
                rdata_d[ACM_RATE_LSB +: 4] = rate_q;
                rdata_d[ACM_FILT_LSB +: 3] = filt_q;
            end
            ACM_VSRC_OFS: begin
                rdata_d[ACM_POS_LSB +: 2] = pos_vsrc_sel;
                rdata_d[ACM_NEG_LSB +: 2] = neg_vsrc_sel;
            end
            ACM_CFG_FOUR_OFS: begin
                rdata_d[3:0] = (dir_q & pin_s) | (~dir_q & data_q);
            end
            ACM_PORT_CFG_OFS: begin
                rdata_d[ACM_CON_LSB +: 4] = con_q;
                rdata_d[ACM_DIR_LSB +: 4] = dir_q;
            end
            ACM_CTRL_OFS: begin
                rdata_d[ACM_EXC_BIT] = exc_q;
            end
            ACM_STATUS_OFS: begin
                rdata_d[ACM_AH_BIT]      = amp_high_alarm;
                rdata_d[ACM_AL_BIT]      = amp_low_alarm;
                rdata_d[ACM_VL_BIT]      = low_vsrc_alarm;
                rdata_d[ACM_SETTLED_BIT] = st_q == ACM_READY;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr <= !hit;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // First config word: rate and filter fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q <= ACM_RATE_RST;
            filt_q <= ACM_FILT_RST;
        end else if (wr_first) begin
            rate_q <= pwdata[ACM_RATE_LSB +: 4];
            filt_q <= pwdata[ACM_FILT_LSB +: 3];
        end
    end

    // Source selectors drive the reference mux directly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pos_vsrc_sel, neg_vsrc_sel} <= ACM_VSRC_RST;
        end else if (wr && paddr == ACM_VSRC_OFS) begin
            pos_vsrc_sel <= pwdata[ACM_POS_LSB +: 2];
            neg_vsrc_sel <= pwdata[ACM_NEG_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con_q  <= ACM_CON_RST;
            dir_q  <= ACM_DIR_RST;
            data_q <= ACM_DATA_RST;
            exc_q  <= 1'b0;
        end else if (wr) begin
            case (paddr)
                ACM_CFG_FOUR_OFS: begin
                    data_q <= pwdata[3:0];
                end
                ACM_PORT_CFG_OFS: begin
                    con_q <= pwdata[ACM_CON_LSB +: 4];
                    dir_q <= pwdata[ACM_DIR_LSB +: 4];
                end
                ACM_CTRL_OFS: begin
                    exc_q <= pwdata[ACM_EXC_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Port pins, shared with analog inputs 0..3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pin_out  <= 4'h0;
            port_pin_oe_n <= 4'hF;
        end else begin
            for (int i = 0; i < 4; i++) begin
                port_pin_oe_n[i] <= !(con_q[i] &&
                                      (exc_q || !dir_q[i]));
                port_pin_out[i]  <= exc_q ? exc_drive[i]
                                          : data_q[i];
            end
        end
    end

    // Alarm flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_high_alarm <= 1'b0;
            amp_low_alarm  <= 1'b0;
            low_vsrc_alarm <= 1'b0;
        end else begin
            amp_high_alarm <= alarm_next(amp_high_alarm,
                                         hi_s && !mux_s,
                                         conv_start);
            amp_low_alarm  <= alarm_next(amp_low_alarm,
                                         lo_s && !mux_s,
                                         conv_start);
            low_vsrc_alarm <= alarm_next(low_vsrc_alarm, vl_s,
                                         conv_start);
        end
    end

    // Filter settings; FIR caps the rate at 20 SPS
    always_comb begin
        rate_eff = rate_q > ACM_RATE_MAX ? ACM_RATE_MAX : rate_q;
        if (filt_q[2] && rate_eff > ACM_FIR_MAX) begin
            rate_eff = ACM_FIR_MAX;
        end
        ratio_d = ACM_RATIO[rate_eff];
        need    = filt_q[2] ? 3'h1 : {1'b0, filt_q[1:0]} + 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decim_ratio <= ACM_RATIO[ACM_RATE_RST];
            fir_mode    <= 1'b0;
            sinc_order  <= 2'h0;
        end else begin
            decim_ratio <= ratio_d;
            fir_mode    <= filt_q >= ACM_FILT_FIR;
            sinc_order  <= filt_q[1:0];
        end
    end

    acm_rate_div #(
        .W (ACM_RW)
    ) u_mod_div (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (1'b1),
        .restart (1'b0),
        .ratio   (ACM_RW'(MOD_DIV)),
        .tick_q  (mod_en)
    );

    acm_rate_div #(
        .W (ACM_RW)
    ) u_int_div (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (mod_en),
        .restart (1'b0),
        .ratio   (ACM_RW'(INT_DIV)),
        .tick_q  (int_en)
    );

    // A first config word write or a mux change restarts the output period
    assign restart = wr_first || mux_s;

    acm_rate_div #(
        .W (ACM_RW)
    ) u_out_div (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (int_en),
        .restart (restart),
        .ratio   (decim_ratio),
        .tick_q  (conv_start)
    );

    // Sinc order N needs N periods to settle, FIR only one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q       <= ACM_SETTLE;
            settle_q   <= 3'h0;
            data_ready <= 1'b0;
        end else begin
            data_ready <= 1'b0;
            case (st_q)
                ACM_SETTLE: begin
                    if (restart) begin
                        settle_q <= 3'h0;
                    end else if (conv_start) begin
                        if (settle_q + 3'h1 >= need) begin
                            st_q       <= ACM_READY;
                            data_ready <= 1'b1;
                            settle_q   <= 3'h0;
                        end else begin
                            settle_q <= settle_q + 3'h1;
                        end
                    end
                end
                ACM_READY: begin
                    if (restart) begin
                        st_q <= ACM_SETTLE;
                    end else if (conv_start) begin
                        data_ready <= 1'b1;
                    end
                end
                default: begin
                    st_q <= ACM_SETTLE;
                end
            endcase
        end
    end

    amp_high_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        hi_s && !mux_s |=> amp_high_alarm)
        else $error("high alarm not set");

    amp_low_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        lo_s && !mux_s |=> amp_low_alarm)
        else $error("low alarm not set");

    alarm_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start && !(hi_s && !mux_s) |=> !amp_high_alarm)
        else $error("high alarm not cleared at conversion");

    mux_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        mux_s && !amp_low_alarm |=> !amp_low_alarm)
        else $error("low alarm set during mux change");

    vsrc_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == ACM_VSRC_OFS && pwdata[3:0] == 4'hA
        |=> pos_vsrc_sel == ACM_SRC_EXT0 && neg_vsrc_sel == ACM_SRC_EXT0)
        else $error("external source not selected");

    vsrc_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        vl_s ##1 !vl_s && !conv_start |=> low_vsrc_alarm)
        else $error("low source alarm lost early");

    pin_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        !port_pin_oe_n[0] |-> $past(con_q[0]))
        else $error("unconnected pin driven");

    mod_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        mod_en |=> !mod_en [*7] ##1 mod_en)
        else $error("modulator rate not one eighth");

endmodule

/* File: verification/acm_analog_model.sv */
`timescale 1ns/1ps
module acm_analog_model (
    input  wire logic [15:0] outp_mv,
    input  wire logic [15:0] outn_mv,
    input  wire logic [15:0] vref_mv,
    input  wire logic        mux_busy,
    input  wire logic [3:0]  ext_lvl,
    input  wire logic [3:0]  port_pin_out,
    input  wire logic [3:0]  port_pin_oe_n,
    output logic             amp_hi_cmp,
    output logic             amp_lo_cmp,
    output logic             vsrc_low_cmp,
    output logic             mux_switching,
    output logic [3:0]       port_pin_in
);
    // Thresholds in mV on a 5 V supply
    localparam logic [15:0] HI_MV  = 16'h12C0;
    localparam logic [15:0] LO_MV  = 16'h00C8;
    localparam logic [15:0] REF_MV = 16'h0190;

    assign amp_hi_cmp    = (outp_mv > HI_MV) || (outn_mv > HI_MV);
    assign amp_lo_cmp    = (outp_mv < LO_MV) || (outn_mv < LO_MV);
    assign vsrc_low_cmp  = vref_mv < REF_MV;
    assign mux_switching = mux_busy;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            port_pin_in[i] = !port_pin_oe_n[i] ? port_pin_out[i] : ext_lvl[i];
        end
    end
endmodule

/* File: verification/adc_monitor_vsrc_port_filter_cfg_test.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin failures++; \
    $display("FAIL %s exp %0h got %0h", nm, exp, got); end end
module adc_monitor_vsrc_port_filter_cfg_test;
    import acm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed, rd;
    logic        ahc, alc, vlc, msw, mux_busy, err;
    logic [3:0]  exc_drive, pin_in, pin_out, pin_oe_n, ext_lvl, d;
    logic [1:0]  pos_sel, neg_sel, sinc_order;
    logic        amp_high_alarm, amp_low_alarm, low_vsrc_alarm;
    logic        mod_en, int_en, conv_start, data_ready, fir_mode;
    logic [12:0] decim_ratio;
    logic [15:0] outp_mv, outn_mv, vref_mv;
    int          failures, samples_checked, n;

    acm_ctrl #(.MOD_DIV(8), .INT_DIV(2)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .amp_hi_cmp(ahc),
        .amp_lo_cmp(alc), .vsrc_low_cmp(vlc), .mux_switching(msw),
        .exc_drive(exc_drive), .port_pin_in(pin_in),
        .port_pin_out(pin_out), .port_pin_oe_n(pin_oe_n),
        .pos_vsrc_sel(pos_sel), .neg_vsrc_sel(neg_sel),
        .amp_high_alarm(amp_high_alarm), .amp_low_alarm(amp_low_alarm),
        .low_vsrc_alarm(low_vsrc_alarm), .mod_en(mod_en), .int_en(int_en),
        .conv_start(conv_start), .data_ready(data_ready),
        .fir_mode(fir_mode), .sinc_order(sinc_order),
        .decim_ratio(decim_ratio));

    acm_analog_model model (
        .outp_mv(outp_mv), .outn_mv(outn_mv),
        .vref_mv(vref_mv), .mux_busy(mux_busy), .ext_lvl(ext_lvl),
        .port_pin_out(pin_out), .port_pin_oe_n(pin_oe_n),
        .amp_hi_cmp(ahc), .amp_lo_cmp(alc), .vsrc_low_cmp(vlc),
        .mux_switching(msw), .port_pin_in(pin_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [12:0] exp_ratio(input logic [2:0] f,
                                             input logic [3:0] r);
        logic [3:0] c;
        c = f[2] ? ((r > 4'h4) ? 4'h4 : r) : ((r > 4'hC) ? 4'hC : r);
        return ACM_RATIO[c];
    endfunction

    function automatic logic pulse(input int k);
        return (k == 0) ? mod_en : (k == 1) ? int_en : conv_start;
    endfunction

    function automatic logic alm(input int k);
        return (k == 0) ? amp_high_alarm : (k == 1) ? amp_low_alarm
                                                    : low_vsrc_alarm;
    endfunction

    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK("rdata", e, rd)
        `CHK("slverr", 1'b0, err)
    endtask

    task automatic meas(input int k, input int e);
        int g;
        g = 0;
        while (pulse(k) !== 1'b1 && g < 5000) begin
            @(posedge pclk);
            g++;
        end
        g = 0;
        do begin
            @(posedge pclk);
            g++;
        end while (pulse(k) !== 1'b1 && g < 5000);
        `CHK("period", e, g)
    endtask

    task automatic wait_conv();
        do begin
            @(posedge pclk);
        end while (conv_start !== 1'b1);
    endtask

    task automatic alarm_chk(input int k);
        case (k)
            0: outn_mv <= 16'h1356;
            1: outp_mv <= 16'h0064;
            default: vref_mv <= 16'h012C;
        endcase
        cyc(4);
        `CHK("alarm set", 1'b1, alm(k))
        wait_conv();
        cyc(2);
        `CHK("alarm held", 1'b1, alm(k))
        apb(1'b0, ACM_STATUS_OFS, 32'h0000_0000);
        `CHK("status", 1'b1, rd[k])
        outp_mv <= 16'h09C4;
        outn_mv <= 16'h09C4;
        vref_mv <= 16'h1388;
        wait_conv();
        wait_conv();
        cyc(2);
        `CHK("alarm clear", 1'b0, alm(k))
        $display("test alarm %0d done", k);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        finish_test();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, mux_busy} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        exc_drive = 4'h0;
        ext_lvl = 4'h0;
        outp_mv = 16'h09C4;
        outn_mv = 16'h09C4;
        vref_mv = 16'h1388;
        seed = 32'h80f8;
        failures = 0;
        samples_checked = 0;
        cyc(4);
        presetn <= 1'b1;
        rdc(ACM_CFG_FIRST_OFS, 32'h0000_0004);
        rdc(ACM_VSRC_OFS, 32'h0000_0005);
        rdc(ACM_PORT_CFG_OFS, 32'h0000_00F0);
        `CHK("pos sel", 2'h1, pos_sel)
        `CHK("oe_n", 4'hF, pin_oe_n)
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, ACM_VSRC_OFS, i);
            cyc(1);
            `CHK("pos sel", i[3:2], pos_sel)
            `CHK("neg sel", i[1:0], neg_sel)
        end
        apb(1'b1, ACM_VSRC_OFS, 32'h0000_000A);
        cyc(1);
        `CHK("ext sel", 4'hA, {pos_sel, neg_sel})
        apb(1'b1, ACM_VSRC_OFS, 32'h0000_0005);
        cyc(1);
        `CHK("supply sel", 4'h5, {pos_sel, neg_sel})
        apb(1'b0, 8'h18, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        $display("test source select done");
        for (int f = 0; f < 8; f++) begin
            seed = lfsr(seed);
            d = (f == 0) ? 4'hF : seed[3:0];
            apb(1'b1, ACM_CFG_FIRST_OFS, {25'h0, f[2:0], d});
            cyc(2);
            `CHK("fir", f[2], fir_mode)
            `CHK("order", f[1:0], sinc_order)
            `CHK("ratio", exp_ratio(f[2:0], d), decim_ratio)
        end
        $display("test filter select done");
        apb(1'b1, ACM_CFG_FIRST_OFS, 32'h0000_000C);
        meas(0, 8);
        meas(1, 16);
        meas(2, 32);
        $display("test rates done");
        alarm_chk(0);
        alarm_chk(1);
        alarm_chk(2);
        mux_busy <= 1'b1;
        cyc(4);
        outn_mv <= 16'h1356;
        cyc(40);
        `CHK("mux alarm", 1'b0, amp_high_alarm)
        outn_mv <= 16'h09C4;
        cyc(4);
        mux_busy <= 1'b0;
        $display("test mux done");
        seed = lfsr(seed);
        d = seed[3:0];
        ext_lvl <= ~d;
        apb(1'b1, ACM_PORT_CFG_OFS, 32'h0000_000F);
        apb(1'b1, ACM_CFG_FOUR_OFS, {28'h0, d});
        cyc(2);
        `CHK("oe_n", 4'h0, pin_oe_n)
        `CHK("pin out", d, pin_out)
        apb(1'b1, ACM_PORT_CFG_OFS, 32'h0000_0000);
        cyc(3);
        `CHK("oe_n", 4'hF, pin_oe_n)
        rdc(ACM_CFG_FOUR_OFS, {28'h0, d});
        apb(1'b1, ACM_PORT_CFG_OFS, 32'h0000_00FF);
        cyc(4);
        rdc(ACM_CFG_FOUR_OFS, {28'h0, ~d});
        `CHK("oe_n", 4'hF, pin_oe_n)
        apb(1'b1, ACM_PORT_CFG_OFS, 32'h0000_000F);
        apb(1'b1, ACM_CTRL_OFS, 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            exc_drive <= seed[3:0];
            cyc(3);
            `CHK("exc out", exc_drive, pin_out)
        end
        apb(1'b1, ACM_CTRL_OFS, 32'h0000_0000);
        $display("test port done");
        apb(1'b1, ACM_CFG_FIRST_OFS, 32'h0000_0044);
        wait_conv();
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (data_ready !== 1'b1 && n < 3);
        `CHK("fir settled", 1'b1, n < 3)
        apb(1'b1, ACM_CFG_FIRST_OFS, 32'h0000_003C);
        n = 0;
        do begin
            @(posedge pclk);
            if (conv_start === 1'b1) begin
                n++;
            end
        end while (data_ready !== 1'b1);
        `CHK("sinc4 settle", 4, n)
        rdc(ACM_STATUS_OFS, 32'h0000_0008);
        $display("test fir done");
        finish_test();
    end
endmodule
